// [hdl/angle_sensor_pkg.sv]
// Package of the angle sensor readout core: frame layout, addresses,
// reset values, timing constants and carrier structs.
// Assumes a 100 MHz core clock; all users refer to it by full name.
package angle_sensor_pkg;

	// Angle and serial frame geometry
	localparam int ANGLE_BITS = 13;
	localparam int FRAME_BITS = 24;
	localparam int COUNT_BITS = 5;
	localparam int PERIOD_BITS = 24;

	// Command frame fields
	localparam int CMD_WRITE_POS = 23;
	localparam int CMD_ADDR_MSB = 22;
	localparam int CMD_ADDR_LSB = 21;

	// Reply frame flag positions, data in the low bits
	localparam int REPLY_INTERNAL_ERROR_FLAG_POS = 23;
	localparam int REPLY_MAGNET_POS = 22;
	localparam int REPLY_ECC_DET_POS = 21;
	localparam int REPLY_ECC_COR_POS = 20;
	localparam int REPLY_SUPPLY_POS = 19;
	localparam int REPLY_VCC_LOW_POS = 18;

	// Register addresses
	localparam logic [1:0] ADDR_ANGLE = 2'h0;
	localparam logic [1:0] ADDR_CONTROL = 2'h1;
	localparam logic [1:0] ADDR_REFERENCE = 2'h2;
	localparam logic [1:0] ADDR_STATUS = 2'h3;

	// Control register fields
	localparam int CTRL_CLEAR_SUPPLY_POS = 0;
	localparam int CTRL_LOW_SPEED_POS = 2;
	localparam int CTRL_AVG_LSB = 3;
	localparam int CTRL_AVG_MSB = 5;

	// Reset values
	localparam logic [12:0] ANGLE_RESET = 13'h0000;
	localparam logic [23:0] REPLY_RESET = 24'h000000;

	// Timing
	localparam int CLK_MHZ = 100;
	localparam int BASE_PERIOD_US = 25;
	localparam int BASE_PERIOD_CYC = BASE_PERIOD_US * CLK_MHZ;
	localparam int POWER_ON_US = 10;
	localparam int POWER_ON_CYC = POWER_ON_US * CLK_MHZ;
	localparam int WATCHDOG_PERIODS = 2;
	localparam int HIGH_SPEED_DROP_BITS = 3;
	localparam logic [7:0] FIELD_LOW_LIMIT = 8'h10;

	// Settings restored from non-volatile memory at power-up
	typedef struct packed {
		logic        lowSpeed;
		logic [2:0]  averagingSetting;
		logic [12:0] referenceAngle;
	} nv_cfg_s;

	// Diagnostic flags carried in every reply
	typedef struct packed {
		logic internalError;
		logic magnetMissing;
		logic eccDetected;
		logic eccCorrected;
		logic supplyLost;
		logic vccLow;
	} diag_s;

	// Power-up sequencing
	typedef enum logic [2:0] {
		ST_POWER_ON = 3'b001,
		ST_LOAD     = 3'b010,
		ST_RUN      = 3'b100
	} power_state_e;

endpackage

// [hdl/pin_sync.sv]
// Two-flop synchroniser for inputs from outside the core clock domain.
// Assumes the inputs are levels that stay stable for several clocks.
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	// Raw and synchronised levels
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] firstStage;

	// First stage feeds only the second
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			firstStage <= '0;
			syncOut <= '0;
		end else begin
			firstStage <= asyncIn;
			syncOut <= firstStage;
		end
	end

endmodule

// [hdl/angle_sampler.sv]
// Free-running refresh timer that marks each new angle sample.
// Assumes the period input is stable between ticks.
`timescale 1ns/1ps
module angle_sampler #(
	parameter int PERIOD_BITS = 24
) (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	// Control
	input  wire logic                   enable,
	input  wire logic [PERIOD_BITS-1:0] periodCycles,
	// Sample strobe
	output logic                        tick
);

	logic [PERIOD_BITS-1:0] count;

	// Count up one period, strobe at its end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			tick <= 1'b0;
		end else if (!enable) begin
			count <= '0;
			tick <= 1'b0;
		end else if (count + 1'b1 >= periodCycles) begin
			count <= '0;
			tick <= 1'b1;
		end else begin
			count <= count + 1'b1;
			tick <= 1'b0;
		end
	end

endmodule

// [hdl/angle_sensor_readout_core.sv]
// Readout core of a magnetic angle sensor: refresh timer, reference
// subtraction, diagnostics, power-up sequencing and a polled serial slave.
// Assumes front end and non-volatile inputs on core_clk; serial and
// supply pins arrive asynchronously.
// Function
// - A fresh angle is produced every refresh period, regardless of host.
// - High speed mode updates each period with ten effective bits.
// - Sampling runs free of the serial port; reads return the latest sample.
// - Latency never exceeds two sample periods plus two serial frames.
// - Best-case latency is one and a half serial frames.
// - After power-up an initialisation lasting the power-on time runs first.
// - Every power-up returns all serial registers to their defaults.
// - Speed mode loads from non-volatile setting; that memory stays unchanged.
// - A watchdog supervises the logic and sets the internal error flag.
// - A weak field sets the magnet missing flag.
// - Non-volatile read errors detected or corrected are flagged in replies.
// - Loss of supply sets the supply lost flag.
// - Reported angle is raw angle minus reference angle.
// - Writing one to control bit two selects low speed mode.
// - Angle is a thirteen-bit unsigned fraction of a turn.
// - Serial data goes out most significant bit first, same in every mode.
// - Low supply flag travels in the angle reply.
// - Low speed period is 25 us times two to the averaging setting.
`timescale 1ns/1ps
module angle_sensor_readout_core #(
	parameter int BASE_PERIOD_CYC = angle_sensor_pkg::BASE_PERIOD_CYC,
	parameter int POWER_ON_CYC    = angle_sensor_pkg::POWER_ON_CYC
) (
	// Clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       rst_n,
	// Hall front end
	input  wire logic [12:0]                rawAngle,
	input  wire logic [7:0]                 fieldLevel,
	// Non-volatile memory after error correction
	input  wire angle_sensor_pkg::nv_cfg_s  nvCfg,
	input  wire logic                       nvEccDetected,
	input  wire logic                       nvEccCorrected,
	// Supply monitor pins
	input  wire logic                       supplyLostPin,
	input  wire logic                       vccLowPin,
	// Serial slave pins
	input  wire logic                       spiClk,
	input  wire logic                       spiCsN,
	input  wire logic                       spiMosi,
	output logic                            spiMiso,
	output logic                            spiMisoOe,
	// Status
	output logic                            powerOnDone,
	output logic                            lowSpeedMode,
	output angle_sensor_pkg::diag_s         diag
);

	localparam int FB = angle_sensor_pkg::FRAME_BITS;

	// Refuse periods the counter cannot hold
	if (BASE_PERIOD_CYC < 1 || BASE_PERIOD_CYC * 128 >= 2 ** angle_sensor_pkg::PERIOD_BITS)
		$error("BASE_PERIOD_CYC out of range");
	if (POWER_ON_CYC < 2 || POWER_ON_CYC >= 2 ** 20)
		$error("POWER_ON_CYC out of range");

	// Raw minus reference, wrapped within one turn
	function automatic logic [12:0] wrapAngle(input logic [12:0] raw, input logic [12:0] ref0);
		wrapAngle = 13'(raw - ref0);
	endfunction

	// Refresh period for the current mode
	function automatic logic [23:0] periodFor(input logic lowSpeed, input logic [2:0] averaging_setting);
		periodFor = lowSpeed ? 24'(24'(BASE_PERIOD_CYC) << averaging_setting) : 24'(BASE_PERIOD_CYC);
	endfunction

	angle_sensor_pkg::power_state_e state;
	logic [19:0] powerCount;
	logic [2:0]  averaging;
	logic [12:0] referenceAngle;
	logic [12:0] angleOut;
	logic [12:0] angleDiff;
	logic [23:0] periodCycles;
	logic        tick;
	logic [23:0] watchdogCount;
	logic        supplySync;
	logic        vccLowSync;
	logic        sclkSync;
	logic        csNSync;
	logic        mosiSync;
	logic        sclkPrev;
	logic        csNPrev;
	logic [FB-1:0] shiftIn;
	logic [FB-1:0] shiftOut;
	logic [FB-1:0] replyWord;
	logic [4:0]  bitCount;
	logic        running;
	logic        sclkRise;
	logic        sclkFall;
	logic        frameStart;
	logic        frameEnd;
	logic        execute;
	logic        cmdWrite;
	logic [1:0]  cmdAddr;

	// Bring pins into the core domain
	pin_sync #(.WIDTH(5)) u_pin_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.asyncIn  ({supplyLostPin, vccLowPin, spiClk, spiCsN, spiMosi}),
		.syncOut  ({supplySync, vccLowSync, sclkSync, csNSync, mosiSync})
	);

	// Power-up sequence: wait, load non-volatile settings, run
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= angle_sensor_pkg::ST_POWER_ON;
			powerCount <= '0;
		end else begin
			case (state)
				angle_sensor_pkg::ST_POWER_ON: begin
					powerCount <= powerCount + 20'h00001;
					if (powerCount == 20'(POWER_ON_CYC - 2))
						state <= angle_sensor_pkg::ST_LOAD;
				end
				angle_sensor_pkg::ST_LOAD: state <= angle_sensor_pkg::ST_RUN;
				angle_sensor_pkg::ST_RUN: state <= angle_sensor_pkg::ST_RUN;
				default: state <= angle_sensor_pkg::ST_POWER_ON;
			endcase
		end
	end

	assign running = (state == angle_sensor_pkg::ST_RUN);
	assign powerOnDone = running;

	// Serial edges and frame boundaries from synchronised pins
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclkPrev <= 1'b0;
			csNPrev <= 1'b1;
		end else begin
			sclkPrev <= sclkSync;
			csNPrev <= csNSync;
		end
	end

	assign sclkRise = sclkSync & ~sclkPrev & ~csNSync;
	assign sclkFall = ~sclkSync & sclkPrev & ~csNSync;
	assign frameStart = csNPrev & ~csNSync & running;
	assign frameEnd = ~csNPrev & csNSync;
	assign execute = frameEnd && running && bitCount == 5'(FB);
	assign cmdWrite = shiftIn[angle_sensor_pkg::CMD_WRITE_POS];
	assign cmdAddr = shiftIn[angle_sensor_pkg::CMD_ADDR_MSB:angle_sensor_pkg::CMD_ADDR_LSB];

	// Control and reference registers, defaults from memory at load
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lowSpeedMode <= 1'b0;
			averaging <= '0;
			referenceAngle <= angle_sensor_pkg::ANGLE_RESET;
		end else if (state == angle_sensor_pkg::ST_LOAD) begin
			lowSpeedMode <= nvCfg.lowSpeed;
			averaging <= nvCfg.averagingSetting;
			referenceAngle <= nvCfg.referenceAngle;
		end else if (execute && cmdWrite && cmdAddr == angle_sensor_pkg::ADDR_CONTROL) begin
			lowSpeedMode <= shiftIn[angle_sensor_pkg::CTRL_LOW_SPEED_POS];
			averaging <= shiftIn[angle_sensor_pkg::CTRL_AVG_MSB:angle_sensor_pkg::CTRL_AVG_LSB];
		end else if (execute && cmdWrite && cmdAddr == angle_sensor_pkg::ADDR_REFERENCE) begin
			referenceAngle <= shiftIn[12:0];
		end
	end

	// Free-running refresh timer
	assign periodCycles = periodFor(lowSpeedMode, averaging);

	angle_sampler #(.PERIOD_BITS(angle_sensor_pkg::PERIOD_BITS)) u_angle_sampler (
		.core_clk     (core_clk),
		.rst_n        (rst_n),
		.enable       (running),
		.periodCycles (periodCycles),
		.tick         (tick)
	);

	// Raw minus reference, a named net so its bits can be selected
	assign angleDiff = wrapAngle(rawAngle, referenceAngle);

	// Capture the offset-corrected angle on every tick
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			angleOut <= angle_sensor_pkg::ANGLE_RESET;
		end else if (tick && lowSpeedMode) begin
			angleOut <= angleDiff;
		end else if (tick) begin
			angleOut <= {angleDiff[12:3], 3'h0};
		end
	end

	// Watchdog over the sample cadence
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			watchdogCount <= '0;
		end else begin
			watchdogCount <= (tick || !running) ? 24'h000000 : watchdogCount + 24'h000001;
		end
	end

	// Watchdog, field, supply and memory diagnostics; one process owns diag
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			diag.internalError <= 1'b0;
			diag.magnetMissing <= 1'b0;
			diag.eccDetected <= 1'b0;
			diag.eccCorrected <= 1'b0;
			diag.supplyLost <= 1'b0;
			diag.vccLow <= 1'b0;
		end else begin
			if (watchdogCount > 24'(angle_sensor_pkg::WATCHDOG_PERIODS) * periodCycles)
				diag.internalError <= 1'b1;
			if (tick)
				diag.magnetMissing <= fieldLevel < angle_sensor_pkg::FIELD_LOW_LIMIT;
			if (state == angle_sensor_pkg::ST_LOAD) begin
				diag.eccDetected <= nvEccDetected;
				diag.eccCorrected <= nvEccCorrected;
			end
			if (supplySync)
				diag.supplyLost <= 1'b1;
			else if (execute && cmdWrite && cmdAddr == angle_sensor_pkg::ADDR_CONTROL
				&& shiftIn[angle_sensor_pkg::CTRL_CLEAR_SUPPLY_POS])
				diag.supplyLost <= 1'b0;
			diag.vccLow <= vccLowSync;
		end
	end

	// Receive shifter and bit counter
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			shiftIn <= '0;
			bitCount <= '0;
		end else if (frameStart) begin
			bitCount <= '0;
		end else if (sclkRise && bitCount != 5'(FB)) begin
			shiftIn <= {shiftIn[FB-2:0], mosiSync};
			bitCount <= bitCount + 5'h01;
		end
	end

	// Reply for the next frame, taken from the latest sample
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			replyWord <= angle_sensor_pkg::REPLY_RESET;
		end else if (execute) begin
			replyWord <= {diag, 5'h00, 13'h0000};
			case (cmdAddr)
				angle_sensor_pkg::ADDR_ANGLE: replyWord[12:0] <= angleOut;
				angle_sensor_pkg::ADDR_CONTROL:
					replyWord[12:0] <= {7'h00, averaging, lowSpeedMode, 2'h0};
				angle_sensor_pkg::ADDR_REFERENCE: replyWord[12:0] <= referenceAngle;
				default: replyWord[12:0] <= {12'h000, powerOnDone};
			endcase
		end
	end

	// Transmit shifter, most significant bit first
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			shiftOut <= '0;
		end else if (frameStart) begin
			shiftOut <= replyWord;
		end else if (sclkFall) begin
			shiftOut <= {shiftOut[FB-2:0], 1'b0};
		end
	end

	assign spiMiso = shiftOut[FB-1];
	assign spiMisoOe = ~csNSync & running;

	// Helper: cycles since the previous tick
	logic [23:0] tickGap;
	logic        tickSeen;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tickGap <= '0;
			tickSeen <= 1'b0;
		end else begin
			tickGap <= tick ? 24'h000001 : tickGap + 24'h000001;
			if (tick)
				tickSeen <= 1'b1;
		end
	end

	sequence loadStep;
		state == angle_sensor_pkg::ST_POWER_ON ##1 state == angle_sensor_pkg::ST_LOAD;
	endsequence

	sequence ctrlWrite;
		execute && cmdWrite && cmdAddr == angle_sensor_pkg::ADDR_CONTROL;
	endsequence

	chk_refresh_period: assert property (@(posedge core_clk) disable iff (!rst_n)
		tick && tickSeen && $stable(periodCycles) |-> tickGap == periodCycles)
		else $error("refresh period wrong");
	chk_angle_offset: assert property (@(posedge core_clk) disable iff (!rst_n)
		tick && lowSpeedMode |=> angleOut == 13'($past(rawAngle) - $past(referenceAngle)))
		else $error("angle offset wrong");
	chk_high_speed_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
		tick && !lowSpeedMode |=> angleOut[2:0] == 3'h0)
		else $error("high speed angle not ten bits");
	chk_power_on_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
		!running |-> !spiMisoOe && !tick)
		else $error("activity during power-on");
	chk_nv_mode_load: assert property (@(posedge core_clk) disable iff (!rst_n)
		loadStep |=> running && lowSpeedMode == $past(nvCfg.lowSpeed))
		else $error("speed mode not loaded");
	chk_low_speed_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		ctrlWrite ##0 shiftIn[angle_sensor_pkg::CTRL_LOW_SPEED_POS] |=> lowSpeedMode)
		else $error("low speed write lost");
	chk_supply_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
		supplySync |=> diag.supplyLost)
		else $error("supply flag not set");
	chk_magnet_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
		tick && fieldLevel < angle_sensor_pkg::FIELD_LOW_LIMIT |=> diag.magnetMissing)
		else $error("magnet flag not set");
	chk_watchdog_trip: assert property (@(posedge core_clk) disable iff (!rst_n)
		watchdogCount > 24'(angle_sensor_pkg::WATCHDOG_PERIODS) * periodCycles
		|=> diag.internalError)
		else $error("watchdog did not trip");
	chk_msb_first: assert property (@(posedge core_clk) disable iff (!rst_n)
		frameStart |=> spiMiso == $past(replyWord[FB-1]))
		else $error("first bit not msb");

endmodule

// [sim/spi_host_model.sv]
// Host model: polls the readout core as a mode 0 serial master.
// Assumes the bench calls one task at a time; clock stays low between frames.
`timescale 1ns/1ps
module spi_host_model (
	// Serial pins
	output logic      spiClk,
	output logic      spiCsN,
	output logic      spiMosi,
	input  wire logic spiMiso
);
	// Idle bus
	initial begin
		spiClk = 1'b0;
		spiCsN = 1'b1;
		spiMosi = 1'b0;
	end

	// One 24-bit frame, 80 ns per bit, reply bit taken late in the high phase
	task automatic frame(input logic [23:0] tx, output logic [23:0] rx);
		spiCsN = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			spiMosi = tx[i];
			#40 spiClk = 1'b1;
			#39 rx[i] = spiMiso;
			#1 spiClk = 1'b0;
		end
		#40 spiCsN = 1'b1;
		spiMosi = ~spiMosi; // Released line shows no stale value
		#100;
	endtask

	// Read: command frame, then a frame that fetches the reply
	task automatic readReg(input logic [1:0] addr, output logic [23:0] rx);
		logic [23:0] unused;
		frame({1'b0, addr, 21'h000000}, unused);
		frame(24'h000000, rx);
	endtask

	// Write of a 13-bit value
	task automatic writeReg(input logic [1:0] addr, input logic [12:0] data);
		logic [23:0] unused;
		frame({1'b1, addr, 8'h00, data}, unused);
	endtask
endmodule

// [sim/angle_sensor_readout_core_tb.sv]
// Self-checking bench of the readout core against an integer reference model.
// Assumes short timing parameters and the host model on the serial pins.
`timescale 1ns/1ps
module angle_sensor_readout_core_tb;
	localparam int BASE = 20;
	localparam int PON  = 10;

	logic                      core_clk;
	logic                      rst_n;
	logic [12:0]               rawAngle;
	logic [7:0]                fieldLevel;
	angle_sensor_pkg::nv_cfg_s nvCfg;
	logic                      nvEccDetected;
	logic                      nvEccCorrected;
	logic                      supplyLostPin;
	logic                      vccLowPin;
	logic                      spiClk;
	logic                      spiCsN;
	logic                      spiMosi;
	logic                      spiMiso;
	logic                      spiMisoOe;
	logic                      powerOnDone;
	logic                      lowSpeedMode;
	angle_sensor_pkg::diag_s   diag;
	logic [23:0]               rsp;
	int                        failures;
	int                        comparisons;
	int                        mRef;
	logic                      mLow;
	logic                      mMag;
	logic                      mSup;
	logic                      mVcc;

	angle_sensor_readout_core #(.BASE_PERIOD_CYC(BASE), .POWER_ON_CYC(PON)) dut (
		.core_clk(core_clk), .rst_n(rst_n), .rawAngle(rawAngle), .fieldLevel(fieldLevel),
		.nvCfg(nvCfg), .nvEccDetected(nvEccDetected), .nvEccCorrected(nvEccCorrected),
		.supplyLostPin(supplyLostPin), .vccLowPin(vccLowPin), .spiClk(spiClk),
		.spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
		.powerOnDone(powerOnDone), .lowSpeedMode(lowSpeedMode), .diag(diag));

	spi_host_model host (.spiClk(spiClk), .spiCsN(spiCsN), .spiMosi(spiMosi),
		.spiMiso(spiMiso));

	// 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Expected angle: wrapped difference, low bits dropped in high speed
	function automatic logic [12:0] expAngle();
		int a;
		a = (int'(rawAngle) - mRef) & 8191;
		if (!mLow) begin
			a = a & ~7;
		end
		return 13'(a);
	endfunction

	// Expected reply word
	function automatic logic [23:0] expReply(input logic [12:0] data);
		return {1'b0, mMag, nvEccDetected, nvEccCorrected, mSup, mVcc, 5'h00, data};
	endfunction

	task automatic checkWord(input logic [23:0] got, input logic [23:0] exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic checkFlag(input logic got, input logic exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t %s got %b exp %b", $time, msg, got, exp);
		end
	endtask

	task automatic stepClk(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic readAngle(input string msg);
		host.readReg(angle_sensor_pkg::ADDR_ANGLE, rsp);
		checkWord(rsp, expReply(expAngle()), msg);
	endtask

	// Reset, then power-on sequence and settings restored from memory
	task automatic powerUp();
		rst_n = 1'b0;
		stepClk(12);
		rst_n = 1'b1;
		mRef = int'(nvCfg.referenceAngle);
		mLow = nvCfg.lowSpeed;
		mSup = 1'b0;
		stepClk(PON - 1);
		checkFlag(powerOnDone, 1'b0, "early ready");
		stepClk(1);
		checkFlag(powerOnDone, 1'b1, "ready");
		checkFlag(spiMisoOe, 1'b0, "oe idle");
		checkFlag(lowSpeedMode, mLow, "mode load");
		checkFlag(diag.eccDetected, nvEccDetected, "ecc det");
		checkFlag(diag.eccCorrected, nvEccCorrected, "ecc cor");
	endtask

	task automatic conclude();
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial begin
		#400us;
		failures++;
		conclude();
	end

	initial begin
		failures = 0;
		comparisons = 0;
		void'($urandom(32'ha1fca84b));
		rst_n = 1'b0;
		rawAngle = 13'h0000;
		fieldLevel = 8'h80;
		nvCfg = '{lowSpeed: 1'b0, averagingSetting: 3'h3, referenceAngle: 13'($urandom)};
		nvEccDetected = 1'b1;
		nvEccCorrected = 1'b0;
		supplyLostPin = 1'b0;
		vccLowPin = 1'b0;
		mMag = 1'b0;
		mVcc = 1'b0;
		powerUp();
		// Random references, read right after the raw angle moves
		repeat (5) begin
			mRef = $urandom & 8191;
			host.writeReg(angle_sensor_pkg::ADDR_REFERENCE, 13'(mRef));
			stepClk(1);
			rawAngle = 13'($urandom);
			fieldLevel = 8'($urandom_range(255, 16));
			readAngle("angle");
		end
		// Zero calibration: read at zero position, program it back
		mRef = 0;
		host.writeReg(angle_sensor_pkg::ADDR_REFERENCE, 13'h0000);
		readAngle("raw read");
		mRef = int'(rsp[12:0]);
		host.writeReg(angle_sensor_pkg::ADDR_REFERENCE, rsp[12:0]);
		readAngle("zeroed");
		host.readReg(angle_sensor_pkg::ADDR_REFERENCE, rsp);
		checkWord(rsp, expReply(13'(mRef)), "reference");
		host.readReg(angle_sensor_pkg::ADDR_STATUS, rsp);
		checkWord(rsp, expReply(13'h0001), "status");
		// Low speed, averaging 2
		mLow = 1'b1;
		host.writeReg(angle_sensor_pkg::ADDR_CONTROL, 13'h0014);
		stepClk(4);
		checkFlag(lowSpeedMode, 1'b1, "low speed");
		host.readReg(angle_sensor_pkg::ADDR_CONTROL, rsp);
		checkWord(rsp, expReply(13'h0014), "control read");
		rawAngle = 13'($urandom);
		readAngle("full res");
		// Missing magnet at the limit and just below
		stepClk(1);
		fieldLevel = 8'h0f;
		mMag = 1'b1;
		readAngle("magnet lost");
		checkFlag(diag.magnetMissing, 1'b1, "magnet flag");
		stepClk(1);
		fieldLevel = 8'h10;
		mMag = 1'b0;
		readAngle("magnet back");
		// Supply loss pulse, then cleared over the link
		stepClk(1);
		supplyLostPin = 1'b1;
		mSup = 1'b1;
		stepClk(5);
		supplyLostPin = 1'b0;
		stepClk(5);
		checkFlag(diag.supplyLost, 1'b1, "supply lost");
		readAngle("supply reply");
		host.writeReg(angle_sensor_pkg::ADDR_CONTROL, 13'h0015);
		mSup = 1'b0;
		stepClk(5);
		checkFlag(diag.supplyLost, 1'b0, "supply clear");
		// Low supply flag in the reply
		vccLowPin = 1'b1;
		mVcc = 1'b1;
		stepClk(5);
		readAngle("vcc low");
		stepClk(1);
		vccLowPin = 1'b0;
		mVcc = 1'b0;
		// Averaging 7: new sample within two long periods
		host.writeReg(angle_sensor_pkg::ADDR_CONTROL, 13'h003c);
		stepClk(1);
		rawAngle = 13'($urandom);
		stepClk(2 * (BASE << 7) + 4);
		readAngle("long period");
		// Second power-up restores defaults from changed memory
		nvCfg = '{lowSpeed: 1'b1, averagingSetting: 3'h1, referenceAngle: 13'($urandom)};
		nvEccDetected = 1'b0;
		nvEccCorrected = 1'b1;
		rawAngle = 13'($urandom);
		powerUp();
		readAngle("after repower");
		conclude();
	end
endmodule
